/* File: mmflc_pkg.sv */
package mmflc_pkg;

  // Register map
  localparam int         ADDR_W          = 12;
  localparam logic [11:0] MODE_CFG_OFFSET = 12'h410;
  localparam logic [11:0] RX_LIMIT_OFFSET = 12'h414;

  // Mode register fields
  localparam int SPEED_HI  = 31;
  localparam int SPEED_LO  = 30;
  localparam int RGMII_BIT = 29;
  localparam int SGMII_BIT = 28;
  localparam int BASEX_BIT = 27;
  localparam int HOST_BIT  = 26;
  localparam int TXW_BIT   = 25;
  localparam int RXW_BIT   = 24;
  localparam int RSV_HI    = 23;
  localparam int RSV_LO    = 9;
  localparam int TIMER_HI  = 8;
  localparam int TIMER_LO  = 0;

  // Frame limit register fields
  localparam int RXEN_BIT   = 16;
  localparam int RXLEN_HI   = 14;
  localparam int RXLEN_LO   = 0;
  localparam int RXRSV_HI   = 31;
  localparam int RXRSV_LO   = 17;
  localparam int RXRSV_MID  = 15;

  // Speed codes
  localparam logic [1:0] SPEED_10   = 2'h0;
  localparam logic [1:0] SPEED_100  = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;
  localparam logic [1:0] SPEED_NA   = 2'h3;

  // Reset values and standard limits
  localparam logic        HOST_IF_RESET = 1'h0;
  localparam logic [14:0] RX_LEN_RESET  = 15'h07D0;
  localparam logic [14:0] STD_LEN       = 15'h05EE;
  localparam logic [14:0] VLAN_LEN      = 15'h05F2;
  localparam int          CFG_W         = 17;

  typedef enum logic {
    MMFLC_APPLIED,
    MMFLC_PENDING
  } mmflc_apply_t;

  // Code 11 has no meaning and is never stored
  function automatic logic mmflc_speed_ok(input logic [1:0] code);
    return code != SPEED_NA;
  endfunction : mmflc_speed_ok

endpackage : mmflc_pkg

/* File: mmflc_ifg_apply.sv */
`timescale 1ns/1ps
module mmflc_ifg_apply
  import mmflc_pkg::*;
#(
  parameter int               W         = CFG_W,
  parameter logic [CFG_W-1:0] RESET_CFG = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] pendingCfg,
  input  wire logic         cfgWritten,
  input  wire logic         ifgActive,
  output logic      [W-1:0] activeCfg
);

  mmflc_apply_t state;

  // Pending tracker; a write in the copy cycle keeps it pending
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= MMFLC_APPLIED;
    end else begin
      case (state)
        MMFLC_APPLIED: if (cfgWritten) state <= MMFLC_PENDING;
        MMFLC_PENDING: if (ifgActive && !cfgWritten) state <= MMFLC_APPLIED;
        default:       state <= MMFLC_APPLIED;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      activeCfg <= RESET_CFG[W-1:0];
    end else if (ifgActive && state == MMFLC_PENDING) begin
      activeCfg <= pendingCfg;
    end
  end

  property p_apply_copy;
    @(posedge sys_clk) disable iff (srst)
    (state == MMFLC_PENDING && ifgActive) |=> activeCfg == $past(pendingCfg);
  endproperty
  a_apply_copy: assert property (p_apply_copy)
    else $error("pending config not adopted in gap");

  property p_apply_hold;
    @(posedge sys_clk) disable iff (srst)
    !ifgActive |=> $stable(activeCfg);
  endproperty
  a_apply_hold: assert property (p_apply_hold)
    else $error("active config changed outside gap");

endmodule : mmflc_ifg_apply

/* File: mmflc_rx_limit.sv */
`timescale 1ns/1ps
module mmflc_rx_limit
  import mmflc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        maxFrameEnable,
  input  wire logic [14:0] maxFrameLength,
  input  wire logic        vlanFrameEnable,
  input  wire logic        jumboFrameEnable,
  output logic             rxLimitCheckEnable,
  output logic      [14:0] rxMaxFrameLength
);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rxMaxFrameLength <= STD_LEN;
    end else if (maxFrameEnable) begin
      rxMaxFrameLength <= maxFrameLength;
    end else begin
      rxMaxFrameLength <= vlanFrameEnable ? VLAN_LEN : STD_LEN;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rxLimitCheckEnable <= 1'h0;
    end else begin
      rxLimitCheckEnable <= !jumboFrameEnable;
    end
  end

  property p_std_len;
    @(posedge sys_clk) disable iff (srst)
    !maxFrameEnable |=> rxMaxFrameLength == ($past(vlanFrameEnable) ? 15'h05F2 : 15'h05EE);
  endproperty
  a_std_len: assert property (p_std_len)
    else $error("standard frame limit wrong");

  property p_prog_len;
    @(posedge sys_clk) disable iff (srst)
    maxFrameEnable |=> rxMaxFrameLength == $past(maxFrameLength);
  endproperty
  a_prog_len: assert property (p_prog_len)
    else $error("programmed frame limit not used");

  property p_jumbo;
    @(posedge sys_clk) disable iff (srst)
    jumboFrameEnable |=> !rxLimitCheckEnable;
  endproperty
  a_jumbo: assert property (p_jumbo)
    else $error("limit check active with jumbo frames");

endmodule : mmflc_rx_limit

/* File: mmflc_config_regs.sv */
`timescale 1ns/1ps
// Contract
// - Mode writes accepted anytime; interface adopts them only during inter-frame gaps.
// - Speed at bits 31-30: 10 gigabit, 01 hundred, 00 ten, 11 unused.
// - Speed resets to 1000 code, or 100 code for MII.
// - Bit 29 selects RGMII operation; resets to zero.
// - Bit 28 selects SGMII operation; resets to zero.
// - Bit 27 selects 1000BASE-X operation; resets to zero.
// - Bit 26 reports host interface enable; reads zero here.
// - Wide datapath bits 25 and 24 always read zero.
// - Reserved bits of both registers read zero.
// - Link timer held in bits 8-0; used only in SGMII or 1000BASE-X.
// - Only the speed field is writable unless FULL_MODE_CTRL is set; other mode bits then act reserved.
// - Frame limit disabled: 1518 or 1522 by VLAN setting.
// - Frame limit enabled: programmed length regardless of VLAN.
// - Jumbo reception enabled: frame limit register ignored.
// - Max length field bits 14-0, writable, resets to 0x7D0.
module mmflc_config_regs
  import mmflc_pkg::*;
#(
  parameter bit         PHY_IS_MII      = 1'b0,
  parameter bit         FULL_MODE_CTRL  = 1'b0,
  parameter logic [8:0] LINK_TIMER_INIT = 9'h000
) (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  output logic      [31:0]       regRdData,
  input  wire logic              ifgActive,
  input  wire logic              vlanFrameEnable,
  input  wire logic              jumboFrameEnable,
  output logic      [1:0]        linkSpeed,
  output logic                   rgmiiModeEnable,
  output logic                   sgmiiModeEnable,
  output logic                   baseXModeEnable,
  output logic                   hostIfEnable,
  output logic                   txWideDatapathEnable,
  output logic                   rxWideDatapathEnable,
  output logic      [8:0]        linkTimer,
  output logic                   linkTimerEnable,
  output logic                   rxLimitCheckEnable,
  output logic      [14:0]       rxMaxFrameLength
);

  localparam logic [1:0] SPEED_INIT = PHY_IS_MII ? SPEED_100 : SPEED_1000;

  localparam logic [CFG_W-1:0] CFG_INIT = {SPEED_INIT, 3'h0, HOST_IF_RESET,
                                           2'h0, LINK_TIMER_INIT};

  logic              modeSel;
  logic              rxSel;
  logic              modeWr;
  logic              rxWr;
  logic [1:0]        speedReg;
  logic              rgmiiReg;
  logic              sgmiiReg;
  logic              baseXReg;
  logic [8:0]        timerReg;
  logic              rxEnReg;
  logic [14:0]       rxLenReg;
  logic [31:0]       modeWord;
  logic [31:0]       rxWord;
  logic [CFG_W-1:0]  pendingCfg;
  logic [CFG_W-1:0]  activeCfg;

  // Address decode
  assign modeSel = (regAddr == MODE_CFG_OFFSET);
  assign rxSel   = (regAddr == RX_LIMIT_OFFSET);
  assign modeWr  = regWrEn && modeSel;
  assign rxWr    = regWrEn && rxSel;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      speedReg <= SPEED_INIT;
    end else if (modeWr && mmflc_speed_ok(regWrData[SPEED_HI:SPEED_LO])) begin
      speedReg <= regWrData[SPEED_HI:SPEED_LO]; // Code 11 dropped
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rgmiiReg <= 1'h0;
      sgmiiReg <= 1'h0;
      baseXReg <= 1'h0;
    end else if (modeWr && FULL_MODE_CTRL) begin
      rgmiiReg <= regWrData[RGMII_BIT];
      sgmiiReg <= regWrData[SGMII_BIT];
      baseXReg <= regWrData[BASEX_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      timerReg <= LINK_TIMER_INIT;
    end else if (modeWr && FULL_MODE_CTRL) begin
      timerReg <= regWrData[TIMER_HI:TIMER_LO];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rxEnReg  <= 1'h0;
      rxLenReg <= RX_LEN_RESET;
    end else if (rxWr) begin
      rxEnReg  <= regWrData[RXEN_BIT];
      rxLenReg <= regWrData[RXLEN_HI:RXLEN_LO];
    end
  end

  assign modeWord = {speedReg, rgmiiReg, sgmiiReg, baseXReg, HOST_IF_RESET,
                     2'h0, 15'h0000, timerReg};
  assign rxWord   = {15'h0000, rxEnReg, 1'h0, rxLenReg};

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      regRdData <= 32'h0000_0000;
    end else if (regRdEn && modeSel) begin
      regRdData <= modeWord;
    end else if (regRdEn && rxSel) begin
      regRdData <= rxWord;
    end else begin
      regRdData <= 32'h0000_0000; // Unmapped reads return zero
    end
  end

  // Live copy feeds the interface; wide bits never set
  assign pendingCfg = {speedReg, rgmiiReg, sgmiiReg, baseXReg, HOST_IF_RESET,
                       2'h0, timerReg};

  mmflc_ifg_apply #(
    .W         (CFG_W),
    .RESET_CFG (CFG_INIT)
  ) u_apply (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .pendingCfg (pendingCfg),
    .cfgWritten (modeWr),
    .ifgActive  (ifgActive),
    .activeCfg  (activeCfg)
  );

  // Unpack adopted settings
  assign linkSpeed            = activeCfg[16:15];
  assign rgmiiModeEnable      = activeCfg[14];
  assign sgmiiModeEnable      = activeCfg[13];
  assign baseXModeEnable      = activeCfg[12];
  assign hostIfEnable         = activeCfg[11];
  assign txWideDatapathEnable = activeCfg[10];
  assign rxWideDatapathEnable = activeCfg[9];
  assign linkTimer            = activeCfg[8:0];

  // timer only meaningful in serial modes
  assign linkTimerEnable = sgmiiModeEnable || baseXModeEnable;

  // Limit changes need no gap; the receiver samples per frame
  mmflc_rx_limit u_rx_limit (
    .sys_clk            (sys_clk),
    .srst               (srst),
    .maxFrameEnable     (rxEnReg),
    .maxFrameLength     (rxLenReg),
    .vlanFrameEnable    (vlanFrameEnable),
    .jumboFrameEnable   (jumboFrameEnable),
    .rxLimitCheckEnable (rxLimitCheckEnable),
    .rxMaxFrameLength   (rxMaxFrameLength)
  );

  property p_speed_gap;
    @(posedge sys_clk) disable iff (srst)
    !ifgActive |=> $stable(linkSpeed);
  endproperty
  a_speed_gap: assert property (p_speed_gap)
    else $error("speed changed outside gap");

  property p_speed_adopt;
    @(posedge sys_clk) disable iff (srst)
    (modeWr && regWrData[31:30] != 2'h3) ##2 ifgActive
      |=> linkSpeed == $past(speedReg);
  endproperty
  a_speed_adopt: assert property (p_speed_adopt)
    else $error("speed not adopted in gap");

  property p_speed_write;
    @(posedge sys_clk) disable iff (srst)
    modeWr |=> speedReg == (($past(regWrData[31:30]) == 2'h3) ?
                            $past(speedReg) : $past(regWrData[31:30]));
  endproperty
  a_speed_write: assert property (p_speed_write)
    else $error("speed field write wrong");

  property p_speed_legal;
    @(posedge sys_clk) disable iff (srst)
    regRdEn && modeSel |=> regRdData[31:30] != 2'h3;
  endproperty
  a_speed_legal: assert property (p_speed_legal)
    else $error("unused speed code read back");

  property p_speed_reset;
    @(posedge sys_clk) disable iff (srst)
    $fell(srst) |-> speedReg == (PHY_IS_MII ? 2'h1 : 2'h2) && linkSpeed == speedReg;
  endproperty
  a_speed_reset: assert property (p_speed_reset)
    else $error("speed reset value wrong");

  property p_rgmii;
    @(posedge sys_clk) disable iff (srst)
    modeWr |=> rgmiiReg == (FULL_MODE_CTRL && $past(regWrData[29]));
  endproperty
  a_rgmii: assert property (p_rgmii)
    else $error("RGMII bit write wrong");

  property p_sgmii;
    @(posedge sys_clk) disable iff (srst)
    modeWr |=> sgmiiReg == (FULL_MODE_CTRL && $past(regWrData[28]));
  endproperty
  a_sgmii: assert property (p_sgmii)
    else $error("SGMII bit write wrong");

  property p_basex;
    @(posedge sys_clk) disable iff (srst)
    modeWr |=> baseXReg == (FULL_MODE_CTRL && $past(regWrData[27]));
  endproperty
  a_basex: assert property (p_basex)
    else $error("1000BASE-X bit write wrong");

  property p_host;
    @(posedge sys_clk) disable iff (srst)
    regRdEn && modeSel |=> !regRdData[26] && !hostIfEnable;
  endproperty
  a_host: assert property (p_host)
    else $error("host enable bit not zero");

  property p_wide;
    @(posedge sys_clk) disable iff (srst)
    regRdEn && modeSel |=> regRdData[25:24] == 2'h0 && !txWideDatapathEnable
                           && !rxWideDatapathEnable;
  endproperty
  a_wide: assert property (p_wide)
    else $error("wide datapath bit set");

  property p_rsv_mode;
    @(posedge sys_clk) disable iff (srst)
    regRdEn && modeSel |=> regRdData[23:9] == 15'h0000;
  endproperty
  a_rsv_mode: assert property (p_rsv_mode)
    else $error("mode reserved bits nonzero");

  property p_rsv_rx;
    @(posedge sys_clk) disable iff (srst)
    regRdEn && rxSel |=> regRdData[31:17] == 15'h0000 && !regRdData[15];
  endproperty
  a_rsv_rx: assert property (p_rsv_rx)
    else $error("frame limit reserved bits nonzero");

  property p_timer;
    @(posedge sys_clk) disable iff (srst)
    modeWr |=> timerReg == (FULL_MODE_CTRL ? $past(regWrData[8:0]) : $past(timerReg));
  endproperty
  a_timer: assert property (p_timer)
    else $error("link timer write wrong");

  property p_locked;
    @(posedge sys_clk) disable iff (srst)
    !FULL_MODE_CTRL && modeWr ##[1:2] regRdEn && modeSel
      |=> regRdData[29:0] == {3'h0, 18'h0_0000, LINK_TIMER_INIT};
  endproperty
  a_locked: assert property (p_locked)
    else $error("non-speed mode bit took a write");

  property p_rxlen;
    @(posedge sys_clk) disable iff (srst)
    rxWr ##1 !rxWr ##1 regRdEn && rxSel |=> regRdData[16:0] ==
      {$past(regWrData[16], 3), 1'h0, $past(regWrData[14:0], 3)};
  endproperty
  a_rxlen: assert property (p_rxlen)
    else $error("frame limit write not read back");

  property p_rxlen_reset;
    @(posedge sys_clk) disable iff (srst)
    $fell(srst) |-> rxLenReg == 15'h07D0 && !rxEnReg;
  endproperty
  a_rxlen_reset: assert property (p_rxlen_reset)
    else $error("frame limit reset value wrong");

  property p_rd_once;
    @(posedge sys_clk) disable iff (srst)
    !regRdEn |=> regRdData == 32'h0000_0000;
  endproperty
  a_rd_once: assert property (p_rd_once)
    else $error("read data held beyond one cycle");

  // Checks below watch only what this block drives
  property p_unmapped_rd;
    @(posedge sys_clk) disable iff (srst)
    regRdEn && !modeSel && !rxSel |=> regRdData == 32'h0000_0000;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd)
    else $error("unmapped read not zero");

  property p_rx_write;
    @(posedge sys_clk) disable iff (srst)
    rxWr |=> rxEnReg == $past(regWrData[16]) && rxLenReg == $past(regWrData[14:0]);
  endproperty
  a_rx_write: assert property (p_rx_write)
    else $error("frame limit fields not stored");

  property p_mode_gap;
    @(posedge sys_clk) disable iff (srst)
    !ifgActive |=> $stable({rgmiiModeEnable, sgmiiModeEnable, baseXModeEnable, linkTimer});
  endproperty
  a_mode_gap: assert property (p_mode_gap)
    else $error("interface mode changed outside gap");

  property p_mode_reset;
    @(posedge sys_clk) disable iff (srst)
    $fell(srst) |-> !rgmiiModeEnable && !sgmiiModeEnable && !baseXModeEnable
                    && linkTimer == LINK_TIMER_INIT;
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("interface mode reset value wrong");

  property p_limit_reset;
    @(posedge sys_clk) disable iff (srst)
    $fell(srst) |-> rxMaxFrameLength == 15'h05EE && !rxLimitCheckEnable;
  endproperty
  a_limit_reset: assert property (p_limit_reset)
    else $error("frame limit output reset wrong");

  property p_limit_check;
    @(posedge sys_clk) disable iff (srst)
    !jumboFrameEnable |=> rxLimitCheckEnable;
  endproperty
  a_limit_check: assert property (p_limit_check)
    else $error("limit check off without jumbo frames");

endmodule : mmflc_config_regs

/* File: mmflc_config_regs_tb.sv */
`timescale 1ns/1ps
module mmflc_config_regs_tb;
  import mmflc_pkg::*;

  logic              sys_clk;
  logic              srst;
  logic [ADDR_W-1:0] regAddr;
  logic [31:0]       regWrData;
  logic              regWrEn;
  logic              regRdEn;
  logic [31:0]       regRdData;
  logic              ifgActive;
  logic              vlanFrameEnable;
  logic              jumboFrameEnable;
  logic [1:0]        linkSpeed;
  logic              rgmiiModeEnable;
  logic              sgmiiModeEnable;
  logic              baseXModeEnable;
  logic              hostIfEnable;
  logic              txWideDatapathEnable;
  logic              rxWideDatapathEnable;
  logic [8:0]        linkTimer;
  logic              linkTimerEnable;
  logic              rxLimitCheckEnable;
  logic [14:0]       rxMaxFrameLength;
  logic [31:0]       modeOut;
  logic [31:0]       limOut;
  logic [1:0]        miiSpeed;
  int                errorCnt;
  int                compares;

  // Adopted mode outputs laid out like the register image, timer enable in a reserved slot
  assign modeOut = {linkSpeed, rgmiiModeEnable, sgmiiModeEnable, baseXModeEnable, hostIfEnable,
                    txWideDatapathEnable, rxWideDatapathEnable, linkTimerEnable, 14'h0000,
                    linkTimer};
  assign limOut  = {15'h0000, rxLimitCheckEnable, 1'b0, rxMaxFrameLength};

  mmflc_config_regs mmflc_config_regs_i (
    .sys_clk              (sys_clk),
    .srst                 (srst),
    .regAddr              (regAddr),
    .regWrData            (regWrData),
    .regWrEn              (regWrEn),
    .regRdEn              (regRdEn),
    .regRdData            (regRdData),
    .ifgActive            (ifgActive),
    .vlanFrameEnable      (vlanFrameEnable),
    .jumboFrameEnable     (jumboFrameEnable),
    .linkSpeed            (linkSpeed),
    .rgmiiModeEnable      (rgmiiModeEnable),
    .sgmiiModeEnable      (sgmiiModeEnable),
    .baseXModeEnable      (baseXModeEnable),
    .hostIfEnable         (hostIfEnable),
    .txWideDatapathEnable (txWideDatapathEnable),
    .rxWideDatapathEnable (rxWideDatapathEnable),
    .linkTimer            (linkTimer),
    .linkTimerEnable      (linkTimerEnable),
    .rxLimitCheckEnable   (rxLimitCheckEnable),
    .rxMaxFrameLength     (rxMaxFrameLength)
  );

  // Second copy strapped for an MII PHY; only its reset speed is compared
  mmflc_config_regs #(
    .PHY_IS_MII (1'b1)
  ) mmflc_config_regs_mii_i (
    .sys_clk              (sys_clk),
    .srst                 (srst),
    .regAddr              (regAddr),
    .regWrData            (regWrData),
    .regWrEn              (regWrEn),
    .regRdEn              (regRdEn),
    .regRdData            (),
    .ifgActive            (ifgActive),
    .vlanFrameEnable      (vlanFrameEnable),
    .jumboFrameEnable     (jumboFrameEnable),
    .linkSpeed            (miiSpeed),
    .rgmiiModeEnable      (),
    .sgmiiModeEnable      (),
    .baseXModeEnable      (),
    .hostIfEnable         (),
    .txWideDatapathEnable (),
    .rxWideDatapathEnable (),
    .linkTimer            (),
    .linkTimerEnable      (),
    .rxLimitCheckEnable   (),
    .rxMaxFrameLength     ()
  );

  // Free-running 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // One-cycle write strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge sys_clk);
    regWrEn   <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe, so sample mid-cycle there
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    @(negedge sys_clk);
    cmp(regRdData, exp);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle

  // Open one gap cycle after a write, then look at the adopted outputs
  task automatic adopt();
    @(posedge sys_clk);
    ifgActive <= 1'b1;
    @(posedge sys_clk);
    ifgActive <= 1'b0;
    @(negedge sys_clk);
  endtask : adopt

  task automatic give_verdict();
    if (errorCnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // Watchdog well beyond the fewer than 100 cycles the sequence needs
  initial begin
    repeat (3000) @(posedge sys_clk);
    errorCnt++;
    give_verdict();
  end

  initial begin
    errorCnt         = 0;
    compares         = 0;
    srst             = 1'b1;
    regAddr          = '0;
    regWrData        = '0;
    regWrEn          = 1'b0;
    regRdEn          = 1'b0;
    ifgActive        = 1'b0;
    vlanFrameEnable  = 1'b0;
    jumboFrameEnable = 1'b0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    settle(2);
    cmp(modeOut, 32'h8000_0000);
    cmp({30'h0000_0000, miiSpeed}, 32'h0000_0001);
    cmp(limOut, 32'h0001_05EE);
    rd(MODE_CFG_OFFSET, 32'h8000_0000);
    rd(RX_LIMIT_OFFSET, 32'h0000_07D0);
    @(negedge sys_clk);
    cmp(regRdData, 32'h0000_0000);
    wr(MODE_CFG_OFFSET, 32'h7FFF_FFFF);
    rd(MODE_CFG_OFFSET, 32'h4000_0000);
    settle(4);
    cmp(modeOut, 32'h8000_0000);
    adopt();
    cmp(modeOut, 32'h4000_0000);
    wr(MODE_CFG_OFFSET, 32'hC000_0000);
    adopt();
    cmp(modeOut, 32'h4000_0000);
    rd(MODE_CFG_OFFSET, 32'h4000_0000);
    // every legal code, other bits set in the write
    for (int i = 0; i < 3; i++) begin
      wr(MODE_CFG_OFFSET, {i[1:0], 30'h3FFF_FFFF});
      adopt();
      cmp(modeOut, {i[1:0], 30'h0000_0000});
    end
    wr(12'h418, 32'hFFFF_FFFF);
    rd(12'h418, 32'h0000_0000);
    rd(MODE_CFG_OFFSET, 32'h8000_0000);
    // programmed limit for both VLAN settings
    wr(RX_LIMIT_OFFSET, 32'hFFFF_FFFF);
    rd(RX_LIMIT_OFFSET, 32'h0001_7FFF);
    for (int v = 0; v < 2; v++) begin
      @(posedge sys_clk);
      vlanFrameEnable <= v[0];
      settle(2);
      cmp(limOut, 32'h0001_7FFF);
    end
    wr(RX_LIMIT_OFFSET, 32'h0000_0100);
    rd(RX_LIMIT_OFFSET, 32'h0000_0100);
    settle(1);
    cmp(limOut, 32'h0001_05F2);
    @(posedge sys_clk);
    vlanFrameEnable <= 1'b0;
    settle(2);
    cmp(limOut, 32'h0001_05EE);
    @(posedge sys_clk);
    jumboFrameEnable <= 1'b1;
    settle(2);
    cmp({31'h0000_0000, rxLimitCheckEnable}, 32'h0000_0000);
    @(posedge sys_clk);
    jumboFrameEnable <= 1'b0;
    wr(MODE_CFG_OFFSET, 32'h0000_0000);
    adopt();
    cmp(modeOut, 32'h0000_0000);
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    settle(2);
    cmp(modeOut, 32'h8000_0000);
    cmp({30'h0000_0000, miiSpeed}, 32'h0000_0001);
    rd(RX_LIMIT_OFFSET, 32'h0000_07D0);
    give_verdict();
  end

endmodule : mmflc_config_regs_tb
